// >>> hw/rocs_fir.sv
// One channel 288-tap equal-weight decimation filter on the half-rate enable
`timescale 1ns/1ps
module rocs_fir #(
  parameter int TAPS = rocs_pkg::FIR_TAPS,
  parameter int GAIN = rocs_pkg::FIR_GAIN
) (
  input wire logic pclk,
  input wire logic presetn,
  rocs_fir_if.fir bus
);
  import rocs_pkg::*;
  localparam int SUM_W = $clog2(TAPS) + 2;
  localparam int FILL_W = $clog2(TAPS + 1);
  localparam logic [FILL_W-1:0] FILL_FULL = FILL_W'(TAPS);

  logic [TAPS-1:0] taps_ff;
  logic signed [SUM_W-1:0] sum_ff;
  logic [FILL_W-1:0] fill_ff;

  // ----------------------------------------
  // Tap line and running sum
  // ----------------------------------------
  // Running sum avoids a 288-input adder; all-zero taps count as -1 each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      taps_ff <= '0;
      sum_ff <= -SUM_W'(TAPS);
    end else if (bus.restart) begin
      taps_ff <= '0;
      sum_ff <= -SUM_W'(TAPS);
    end else if (bus.half_en) begin
      taps_ff <= {taps_ff[TAPS-2:0], bus.mod_bit}; // RL1 RL3
      case ({bus.mod_bit, taps_ff[TAPS-1]})
        2'b10: sum_ff <= sum_ff + SUM_W'(2);
        2'b01: sum_ff <= sum_ff - SUM_W'(2);
        default: sum_ff <= sum_ff;
      endcase
    end
  end

  // Fill count: output is meaningless until every tap is new
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_ff <= '0;
    end else if (bus.restart) begin
      fill_ff <= '0;
    end else if (bus.half_en && fill_ff != FILL_FULL) begin
      fill_ff <= fill_ff + FILL_W'(1); // RL4
    end
  end

  assign bus.settled = (fill_ff == FILL_FULL);
  assign bus.word = WORD_W'(sum_ff * GAIN); // RL2

  a_fill_bound: assert property (@(posedge pclk) disable iff (!presetn)
    fill_ff <= FILL_FULL) else $error("fir fill count overran"); // RL4
endmodule

// >>> hw/rocs_fir_if.sv
// Link between the sequencer and one channel decimation filter
`timescale 1ns/1ps
interface rocs_fir_if;
  logic half_en;
  logic restart;
  logic mod_bit;
  logic [14:0] word;
  logic settled;
  modport seq (output half_en, output restart, output mod_bit, input word, input settled);
  modport fir (input half_en, input restart, input mod_bit, output word, output settled);
endinterface

// >>> hw/rocs_pkg.sv
// Constants, register map and state type of the receive offset calibration sequencer
// How it works
// [RL1] Modulator bits taken at half clock rate
// [RL2] Each I/Q word is 15-bit twos complement
// [RL3] Decimation FIR has 288 taps, half-rate
// [RL4] Output meaningless until 288 new taps loaded
// [RL5] Subtract channel offset from filter output
// [RL6] Offset is 10-bit signed twos complement
// [RL7] Offset bits sit at word bits 12..3
// [RL8] Automatic or user offset calibration modes
// [RL9] Auto mode calibrates on each wake-up
// [RL10] Wait 36 symbols after power-on asserts
// [RL11] Then time out the first delay
// [RL12] Auto select low skips calibration entirely
// [RL13] Internal mode shorts inputs; external keeps pins
// [RL14] Average 16 measurements into offset register
// [RL15] Calibration interval lasts 40 x 48 clocks
// [RL16] Second delay timer starts after calibration
// [RL17] Delays 0..255, one unit per bit time
// [RL18] Valid words only after second delay
// [RL19] User mode: host offset never overwritten
// [RL20] Offsets kept while receive path sleeps
// [RL21] User mode: first pair after settling
// [RL22] Receive on if pin or bit high
// [RL23] Auto select bit 1 means automatic
// [RL24] External select 1 keeps pins connected
// [RL25] Power drop abandons sequence, suppresses output
package rocs_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int MCLK_PER_SYMBOL = 48;
  localparam int SETTLE_SYMBOLS = 36;
  localparam int CAL_SYMBOLS = 40;
  localparam int FIR_TAPS = 288;
  localparam int FIR_SETTLE_CYC = FIR_TAPS * 2;
  localparam int AVG_COUNT = 16;
  localparam int AVG_SHIFT = 4;
  localparam logic [15:0] SETTLE_CYC = 16'(SETTLE_SYMBOLS * MCLK_PER_SYMBOL);
  localparam logic [15:0] CAL_CYC = 16'(CAL_SYMBOLS * MCLK_PER_SYMBOL);
  localparam logic [15:0] MEAS_START = 16'(FIR_SETTLE_CYC);
  localparam logic [15:0] MEAS_END = 16'(FIR_SETTLE_CYC + AVG_COUNT * MCLK_PER_SYMBOL);
  localparam logic [5:0] SYM_LAST = 6'(MCLK_PER_SYMBOL - 1);
  localparam logic [4:0] AVG_LAST = 5'(AVG_COUNT);
  // ----------------------------------------
  // Word layout
  // ----------------------------------------
  localparam int WORD_W = 15;
  localparam int OFS_W = 10;
  localparam int OFS_LSB = 3;
  localparam int ACC_W = WORD_W + AVG_SHIFT;
  localparam int FIR_GAIN = 56;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] DLY1_ADDR = 8'h04;
  localparam logic [7:0] DLY2_ADDR = 8'h08;
  localparam logic [7:0] OFS_I_ADDR = 8'h0c;
  localparam logic [7:0] OFS_Q_ADDR = 8'h10;
  localparam logic [7:0] STAT_ADDR = 8'h14;
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CTRL_EXT_BIT = 1;
  localparam int CTRL_PWR_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] DLY_RST = 8'h00;
  localparam logic [9:0] OFS_RST = 10'h000;
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_SETTLE = 3'b001,
    ST_DELAY1 = 3'b010,
    ST_CAL = 3'b011,
    ST_DELAY2 = 3'b100,
    ST_RUN = 3'b101
  } rocs_state_type;
endpackage

// >>> hw/rocs_top.sv
// Receive path sequencer: power-up timing, offset calibration, offset removal, APB registers
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module rocs_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic receive_power_on,
  input wire logic rx_mod_i,
  input wire logic rx_mod_q,
  output logic [rocs_pkg::WORD_W-1:0] rx_word_i,
  output logic [rocs_pkg::WORD_W-1:0] rx_word_q,
  output logic rx_word_valid,
  output logic rx_section_on,
  output logic cal_input_short
);
  import rocs_pkg::*;

  rocs_state_type state_ff;
  rocs_state_type nxt_state;
  logic [2:0] ctrl_ff;
  logic [7:0] dly1_ff;
  logic [7:0] dly2_ff;
  logic [15:0] cnt_ff;
  logic [15:0] cnt_limit;
  logic [5:0] sym_ff;
  logic half_ff;
  logic word_stb;
  logic pwr_on;
  logic [4:0] nsamp_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] rd_data;
  logic addr_hit;
  logic apb_wr;
  logic [OFS_W-1:0] ofs_ff [2];
  logic signed [ACC_W-1:0] acc_ff [2];
  logic [WORD_W-1:0] word_ff [2];
  logic [1:0] mod_vec;
  logic [1:0] settled_vec;
  logic valid_ff;
  logic on_ff;
  logic short_ff;
  logic cal_take;
  logic cal_store;

  // ----------------------------------------
  // Clock dividers
  // ----------------------------------------
  // Half-rate enable and one strobe per bit time (48 clocks)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_ff <= 1'b0;
      sym_ff <= '0;
    end else begin
      half_ff <= ~half_ff; // RL1
      sym_ff <= (sym_ff == SYM_LAST) ? 6'h00 : sym_ff + 6'h01;
    end
  end

  assign word_stb = (sym_ff == SYM_LAST);
  assign mod_vec = {rx_mod_q, rx_mod_i};

  // Pin and control bit are ORed
  assign pwr_on = receive_power_on | ctrl_ff[CTRL_PWR_BIT]; // RL22

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  // One wait state: pready is a flop so the read mux stays off the output path
  assign addr_hit = (paddr == CTRL_ADDR) || (paddr == DLY1_ADDR) || (paddr == DLY2_ADDR) ||
                    (paddr == OFS_I_ADDR) || (paddr == OFS_Q_ADDR) || (paddr == STAT_ADDR);
  assign apb_wr = psel && penable && pready_ff && pwrite && addr_hit;

  // Read mux, reserved bits read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    case (paddr)
      CTRL_ADDR: rd_data = {29'h0000_0000, ctrl_ff};
      DLY1_ADDR: rd_data = {24'h00_0000, dly1_ff};
      DLY2_ADDR: rd_data = {24'h00_0000, dly2_ff};
      OFS_I_ADDR: rd_data = {22'h00_0000, ofs_ff[0]};
      OFS_Q_ADDR: rd_data = {22'h00_0000, ofs_ff[1]};
      STAT_ADDR: rd_data = {26'h000_0000, &settled_vec, on_ff, 1'b0, state_ff};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // Answer handshake and error on unmapped addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= '0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !addr_hit;
      if (psel && penable && !pready_ff && !pwrite) begin
        prdata_ff <= rd_data;
      end
    end
  end

  // Control and delay registers; kept through sleep
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RST;
      dly1_ff <= DLY_RST;
      dly2_ff <= DLY_RST;
    end else if (apb_wr) begin
      if (paddr == CTRL_ADDR) ctrl_ff <= pwdata[2:0]; // RL8 RL23 RL24
      if (paddr == DLY1_ADDR) dly1_ff <= pwdata[7:0]; // RL17
      if (paddr == DLY2_ADDR) dly2_ff <= pwdata[7:0]; // RL17
    end
  end

  // ----------------------------------------
  // Power-up sequencer
  // ----------------------------------------
  // Length of the current state in clocks; delays are bit-time units
  always_comb begin
    cnt_limit = 16'h0000;
    case (state_ff)
      ST_SETTLE: cnt_limit = SETTLE_CYC; // RL10
      ST_DELAY1: cnt_limit = 16'(dly1_ff * MCLK_PER_SYMBOL); // RL11 RL17
      ST_CAL: cnt_limit = CAL_CYC; // RL15
      ST_DELAY2: cnt_limit = 16'(dly2_ff * MCLK_PER_SYMBOL); // RL16 RL17
      default: cnt_limit = 16'h0000;
    endcase
  end

  // A zero delay still costs one clock in its state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_OFF: if (pwr_on) nxt_state = ST_SETTLE;
      ST_SETTLE: if (cnt_ff == cnt_limit - 16'h0001) nxt_state = ST_DELAY1;
      ST_DELAY1: begin
        if (cnt_limit == 16'h0000 || cnt_ff == cnt_limit - 16'h0001) begin
          nxt_state = ctrl_ff[CTRL_AUTO_BIT] ? ST_CAL : ST_DELAY2; // RL9 RL12 RL23
        end
      end
      ST_CAL: if (cnt_ff == cnt_limit - 16'h0001) nxt_state = ST_DELAY2; // RL15 RL16
      ST_DELAY2: begin
        if (cnt_limit == 16'h0000 || cnt_ff == cnt_limit - 16'h0001) begin
          nxt_state = ST_RUN; // RL18
        end
      end
      ST_RUN: nxt_state = ST_RUN;
      default: nxt_state = ST_OFF;
    endcase
    if (!pwr_on) nxt_state = ST_OFF; // RL25
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // State timer restarts on every state change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (nxt_state != state_ff) begin
      cnt_ff <= '0;
    end else if (cnt_ff != 16'hffff) begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end

  // ----------------------------------------
  // Calibration measurement
  // ----------------------------------------
  // Inputs shorted until the measurement window ends at MEAS_END, then a resettle stretch
  assign cal_take = (state_ff == ST_CAL) && word_stb && (cnt_ff >= MEAS_START) &&
                    (cnt_ff < MEAS_END) && (nsamp_ff != AVG_LAST); // RL14
  assign cal_store = (state_ff == ST_CAL) && (nxt_state == ST_DELAY2) &&
                     (nsamp_ff == AVG_LAST); // RL14

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nsamp_ff <= '0;
    end else if (state_ff != ST_CAL) begin
      nsamp_ff <= '0;
    end else if (cal_take) begin
      nsamp_ff <= nsamp_ff + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_ff <= 1'b0;
    end else begin
      // On entry the count still belongs to the previous state, so entry in internal mode always shorts
      short_ff <= (nxt_state == ST_CAL) && !ctrl_ff[CTRL_EXT_BIT] &&
                  (state_ff != ST_CAL || cnt_ff < MEAS_END - 16'h0001); // RL13 RL24
    end
  end

  // ----------------------------------------
  // Per-channel filter, offset and output
  // ----------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_chan
    localparam logic [7:0] OFS_ADDR = 8'(OFS_I_ADDR + 8'(4 * g));
    logic signed [15:0] diff;
    rocs_fir_if fir_bus ();

    assign fir_bus.half_en = half_ff;
    assign fir_bus.restart = (state_ff == ST_OFF); // RL4 RL25
    assign fir_bus.mod_bit = mod_vec[g];
    assign settled_vec[g] = fir_bus.settled;

    rocs_fir u_fir (
      .pclk(pclk),
      .presetn(presetn),
      .bus(fir_bus.fir)
    );

    // Offset sits at word bits 12..3, sign carried above
    assign diff = $signed({fir_bus.word[WORD_W-1], fir_bus.word}) -
                  $signed({{3{ofs_ff[g][OFS_W-1]}}, ofs_ff[g], 3'h0}); // RL5 RL6 RL7

    // Sum of 16 words; divide by 16 is a bit slice at store time
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        acc_ff[g] <= '0;
      end else if (state_ff != ST_CAL) begin
        acc_ff[g] <= '0;
      end else if (cal_take) begin
        acc_ff[g] <= acc_ff[g] + {{AVG_SHIFT{fir_bus.word[WORD_W-1]}}, fir_bus.word}; // RL14
      end
    end

    // Calibration result wins over a host write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ofs_ff[g] <= OFS_RST;
      end else if (cal_store) begin
        ofs_ff[g] <= acc_ff[g][OFS_LSB+AVG_SHIFT +: OFS_W]; // RL14 RL7
      end else if (apb_wr && paddr == OFS_ADDR) begin
        ofs_ff[g] <= pwdata[OFS_W-1:0]; // RL19 RL20
      end
    end

    // Saturate rather than wrap when the offset pushes past full scale
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        word_ff[g] <= '0;
      end else if (state_ff == ST_OFF) begin
        word_ff[g] <= '0;
      end else if (state_ff == ST_RUN && word_stb && fir_bus.settled) begin
        if (diff > 16'sh3fff) begin
          word_ff[g] <= 15'h3fff;
        end else if (diff < 16'shc000) begin
          word_ff[g] <= 15'h4000;
        end else begin
          word_ff[g] <= diff[WORD_W-1:0]; // RL2 RL5
        end
      end
    end
  end

  // ----------------------------------------
  // Output flags
  // ----------------------------------------
  // Valid pulse once per bit time, only with settled filters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_ff <= 1'b0;
      on_ff <= 1'b0;
    end else begin
      valid_ff <= (state_ff == ST_RUN) && pwr_on && word_stb && (&settled_vec); // RL18 RL21 RL25
      on_ff <= pwr_on; // RL22
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign rx_word_i = word_ff[0];
  assign rx_word_q = word_ff[1];
  assign rx_word_valid = valid_ff;
  assign rx_section_on = on_ff;
  assign cal_input_short = short_ff;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_power_drop_off: assert property ( // RL25
    !pwr_on |=> state_ff == ST_OFF && !valid_ff) else $error("sequence kept after power drop");
  a_valid_in_run: assert property ( // RL18
    valid_ff |-> $past(state_ff) == ST_RUN) else $error("valid word outside run state");
  a_user_settled: assert property ( // RL21
    valid_ff |-> $past(settled_vec) == 2'b11) else $error("word before filter settled");
  a_settle_length: assert property ( // RL10
    $rose(state_ff == ST_DELAY1) |-> $past(cnt_ff) == SETTLE_CYC - 16'h0001)
    else $error("settling wait not 36 symbols");
  a_cal_only_auto: assert property ( // RL12
    state_ff == ST_DELAY1 ##1 state_ff == ST_CAL |-> $past(ctrl_ff[CTRL_AUTO_BIT]))
    else $error("calibration ran in user mode");
  a_cal_length: assert property ( // RL15
    state_ff == ST_CAL ##1 state_ff == ST_DELAY2 |-> $past(cnt_ff) == CAL_CYC - 16'h0001)
    else $error("calibration interval wrong length");
  a_short_internal: assert property ( // RL13
    short_ff |-> state_ff == ST_CAL && !$past(ctrl_ff[CTRL_EXT_BIT]))
    else $error("inputs shorted outside internal calibration");
  a_user_offset_kept: assert property ( // RL19
    state_ff != ST_CAL |=> $stable(ofs_ff[0]) || $past(apb_wr))
    else $error("offset changed without host write");
  a_offset_subtract: assert property ( // RL5
    valid_ff && $past(g_chan[0].diff) <= 16'sh3fff && $past(g_chan[0].diff) >= 16'shc000
    |-> rx_word_i == $past(g_chan[0].diff[WORD_W-1:0])) else $error("offset not subtracted");
  a_apb_one_wait: assert property (
    psel && !penable ##1 psel && penable |=> pready_ff ##1 !pready_ff)
    else $error("apb answer timing broken");
  a_sixteen_taken: assert property ( // RL14
    state_ff == ST_CAL ##1 state_ff == ST_DELAY2 |-> $past(nsamp_ff) == AVG_LAST)
    else $error("calibration did not average 16 samples");
  a_off_clears: assert property ( // RL25
    state_ff == ST_OFF |=> rx_word_i == 15'h0000 && rx_word_q == 15'h0000)
    else $error("words kept while receive path off");
  a_section_on: assert property ( // RL22
    on_ff == $past(pwr_on)) else $error("receive section flag not pin or bit");

  c_cal_done: cover property (state_ff == ST_CAL ##1 state_ff == ST_DELAY2);
  c_cal_skipped: cover property (state_ff == ST_DELAY1 ##1 state_ff == ST_DELAY2);
  c_first_word: cover property ($rose(valid_ff));
  c_drop_in_cal: cover property (state_ff == ST_CAL ##1 state_ff == ST_OFF);
  c_ext_cal: cover property (state_ff == ST_CAL && ctrl_ff[CTRL_EXT_BIT]);
endmodule

// >>> test/rocs_rx_model.sv
// Far-side model: modulator bit source and receive word sink
`timescale 1ns/1ps
module rocs_rx_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cal_input_short,
  input wire logic [14:0] rx_word_i,
  input wire logic [14:0] rx_word_q,
  input wire logic rx_word_valid,
  output logic rx_mod_i,
  output logic rx_mod_q,
  output logic [14:0] last_i,
  output logic [14:0] last_q,
  output int word_count
);
  logic [1:0] ph_ff;
  // Phase counter; bit 1 flips every two clocks, so half-rate samples alternate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_ff <= 2'h0;
    else ph_ff <= ph_ff + 2'h1;
  end
  // Shorted inputs give a zero-mean stream; pins give I full high, Q full low
  assign rx_mod_i = cal_input_short ? ph_ff[1] : 1'b1;
  assign rx_mod_q = cal_input_short ? ph_ff[1] : 1'b0;
  // Sink takes each I/Q pair on its strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_i <= 15'h0000;
      last_q <= 15'h0000;
      word_count <= 0;
    end else if (rx_word_valid) begin
      last_i <= rx_word_i;
      last_q <= rx_word_q;
      word_count <= word_count + 1;
    end
  end
endmodule

// >>> test/rocs_top_tb.sv
// Self-checking bench for the receive offset calibration sequencer
`timescale 1ns/1ps
module rocs_top_tb;
  import rocs_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_on, rx_mod_i, rx_mod_q;
  logic [14:0] rx_word_i, rx_word_q, last_i, last_q;
  logic rx_word_valid, rx_section_on, cal_input_short, saw_short;
  int word_count, err_total, total_checks, cyc, lat0;
  logic [31:0] rd;
  logic er;

  rocs_top rocs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .receive_power_on(pin_on), .rx_mod_i(rx_mod_i), .rx_mod_q(rx_mod_q),
    .rx_word_i(rx_word_i), .rx_word_q(rx_word_q), .rx_word_valid(rx_word_valid),
    .rx_section_on(rx_section_on), .cal_input_short(cal_input_short));
  rocs_rx_model rocs_rx_model_inst (.pclk(pclk), .presetn(presetn),
    .cal_input_short(cal_input_short), .rx_word_i(rx_word_i), .rx_word_q(rx_word_q),
    .rx_word_valid(rx_word_valid), .rx_mod_i(rx_mod_i), .rx_mod_q(rx_mod_q),
    .last_i(last_i), .last_q(last_q), .word_count(word_count));

  // 125 MHz clock
  always #4 pclk = ~pclk;
  initial pin_on = 1'b0;

  // --------------------------------
  // Shared tasks
  // --------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Counts clocks until the next word strobe, noting any input short
  task automatic wait_valid(output int n);
    n = 0;
    saw_short = 1'b0;
    do begin
      @(posedge pclk);
      n++;
      if (cal_input_short === 1'b1) saw_short = 1'b1;
    end while (rx_word_valid !== 1'b1);
  endtask

  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_regs();
    apb(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, DLY2_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_Q_ADDR, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h18, 32'hffff_ffff);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
  endtask

  // User mode: host offsets used as written, then power drop
  task automatic t_user();
    int n;
    apb(1'b1, OFS_I_ADDR, 32'h010);
    apb(1'b1, OFS_Q_ADDR, 32'h3f0);
    pin_on <= 1'b1;
    wait_valid(n);
    lat0 = n;
    chk({31'h0, n >= 1730 && n <= 1830}, 32'h1);
    chk({17'h0, rx_word_i}, 32'h3e80);
    chk({17'h0, rx_word_q}, 32'h4180);
    chk({31'h0, rx_section_on}, 32'h1);
    @(posedge pclk);
    chk({1'b0, last_i, 1'b0, last_q}, 32'h3e80_4180);
    pin_on <= 1'b0;
    repeat (3) @(posedge pclk);
    n = word_count;
    chk({rx_section_on, 16'h0, rx_word_i}, 32'h0);
    repeat (200) @(posedge pclk);
    chk(word_count - n, 32'h0);
    apb(1'b0, OFS_I_ADDR, 32'h0);
    chk(rd, 32'h010);
  endtask

  // Largest first delay and a short second delay stretch the start
  task automatic t_delay();
    int n;
    apb(1'b1, DLY1_ADDR, 32'hff);
    apb(1'b1, DLY2_ADDR, 32'h03);
    pin_on <= 1'b1;
    wait_valid(n);
    chk({31'h0, n - lat0 >= 12334 && n - lat0 <= 12430}, 32'h1);
    chk({31'h0, saw_short}, 32'h0);
    apb(1'b0, STAT_ADDR, 32'h0);
    chk(rd, 32'h35);
    @(posedge pclk);
    pin_on <= 1'b0;
    apb(1'b1, DLY1_ADDR, 32'h0);
    apb(1'b1, DLY2_ADDR, 32'h0);
  endtask

  // Automatic calibration woken by the control bit, internal or external
  task automatic t_auto(input logic ext);
    int n;
    apb(1'b1, OFS_I_ADDR, 32'h055);
    apb(1'b1, CTRL_ADDR, {29'h0, 1'b1, ext, 1'b1});
    wait_valid(n);
    chk({31'h0, n >= 3649 && n <= 3760}, 32'h1);
    chk({31'h0, saw_short}, {31'h0, ~ext});
    chk({1'b0, rx_word_i, 1'b0, rx_word_q}, ext ? 32'h3fff_4000 : 32'h3f00_4100);
    apb(1'b0, OFS_I_ADDR, 32'h0);
    chk(rd, ext ? 32'h3e0 : 32'h000);
    apb(1'b0, OFS_Q_ADDR, 32'h0);
    chk(rd, ext ? 32'h020 : 32'h000);
    apb(1'b1, CTRL_ADDR, 32'h0);
    repeat (4) @(posedge pclk);
  endtask

  // --------------------------------
  // Main sequence and hang guard
  // --------------------------------
  initial begin
    err_total = 0;
    total_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_user();
    t_delay();
    t_auto(1'b0);
    t_auto(1'b1);
    final_report();
  end

  // Whole run needs about 24000 clocks
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end
endmodule
